// file: hw/bwsg_top.sv
// Purpose: Bus cycle sequencer that inserts wait states between T2 and T3.
// Assumes: The wait pin is synchronous to i_clock and changes on the rising edge.
// Notes: One i_clock cycle stands for one bus clock state; the falling-edge
// sample is taken as the pin level during the state.
//
// Contract
// R1 - Wait is requested when the pin or the programmed generator asks.
// R2 - CPU cycles and DMA cycles are stretched alike.
// R3 - Wait states sit between T2 and T3, lengthening the cycle.
// R4 - The wait pin is sampled in T2 and in each wait state.
// R5 - Pin low inside a wait state adds one more wait state.
// R6 - The far device changes the wait pin on the rising clock edge.
// R7 - No refresh cycle is granted while a wait state runs.
// R8 - The cycle gets the larger of pin waits and programmed waits.
// R9 - Memory cycles get 0 to 3 waits from the memory field.
// R10 - External I/O cycles get 1 to 4 waits from the I/O field.
// R11 - Interrupt 0 acknowledge with fetch output low gets 2, 4, 5 or 6 waits.
// R12 - Other interrupt acknowledges get 2 waits; NMI with fetch output low none.
// R13 - On-chip I/O ignores the I/O field; data registers take 0 to 4.
// R14 - Other on-chip registers take no waits and three clocks.
// R15 - Acknowledge cycles with fetch output high use the memory setting; the code does so for INT0 and NMI only, other acknowledges get 2.
// R16 - Reset sets all four wait bits, giving 3 and 4 waits.
// R17 - Fetch output is low on opcode fetch, interrupt 0 and NMI first cycle.
// R18 - Fetch, memory and I/O cycles last three clocks plus waits.
// R19 - Each wait state is one clock with bus outputs held steady.
// R20 - Programmed count runs from the first wait; end needs count done and pin high.
module bwsg_top
	import bwsg_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_enable,
	input wire logic i_wait_n,
	input wire logic i_cycle_valid,
	input wire bwsg_cycle_s i_cycle,
	input wire logic i_nmi_first_cycle,
	input wire bwsg_reg_write_s i_reg_write,
	input wire logic i_refresh_request,
	output logic o_cycle_ready,
	output logic o_cycle_done,
	output logic o_bus_active,
	output logic [15:0] o_address,
	output logic o_from_dma,
	output logic o_last_instruction_fetch_n,
	output logic o_in_wait,
	output logic o_refresh_grant,
	output logic [1:0] o_memory_wait_count,
	output logic [1:0] o_io_wait_count,
	output logic [7:0] o_dma_and_wait_control,
	output logic [2:0] o_waits_inserted
);

	// ----------------------------------------
	// Control register and wait count decode
	// ----------------------------------------
	logic [7:0] control;
	logic [1:0] memory_wait_count_high_low;
	logic [1:0] io_wait_count_high_low;
	logic [2:0] decoded_waits;
	logic fetch_low_for_request;

	bwsg_control_reg u_control (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_enable(i_enable),
		.i_write(i_reg_write),
		.o_dma_and_wait_control(control)
	);

	assign memory_wait_count_high_low = control[BWSG_MEMORY_WAIT_POS +: 2];
	assign io_wait_count_high_low = control[BWSG_IO_WAIT_POS +: 2];

	// Fetch output is low on opcode fetch, interrupt 0 acknowledge and
	// the first machine cycle of an NMI acknowledge.
	always_comb begin
		case (i_cycle.kind)
			BWSG_KIND_OPCODE, BWSG_KIND_INT0_ACK: fetch_low_for_request = 1'b1; // see R17
			BWSG_KIND_NMI_ACK: fetch_low_for_request = i_nmi_first_cycle; // see R17
			default: fetch_low_for_request = 1'b0;
		endcase
	end

	// The DMA flag does not enter the decode, so both masters get equal waits.
	bwsg_count_decode u_decode (
		.i_cycle(i_cycle),
		.i_memory_wait(memory_wait_count_high_low),
		.i_io_wait(io_wait_count_high_low),
		.i_last_instruction_fetch_n(~fetch_low_for_request),
		.o_waits(decoded_waits)
	); // see R2

	// ----------------------------------------
	// Bus cycle state machine
	// ----------------------------------------
	bwsg_state_e state;
	bwsg_state_e next_state;
	logic [2:0] remaining;
	logic [2:0] next_remaining;
	logic [2:0] inserted;
	logic [2:0] next_inserted;
	logic [15:0] address;
	logic [15:0] next_address;
	logic from_dma;
	logic next_from_dma;
	logic fetch_n;
	logic next_fetch_n;
	logic refresh_grant;
	logic next_refresh_grant;
	logic wait_needed;
	logic count_left;

	// A cycle that already has enough waits still stretches while the pin is
	// low, so the result is the larger of the two demands.
	always_comb begin
		count_left = (remaining != 3'h0);
		wait_needed = count_left || !i_wait_n; // see R1, R8
	end

	always_comb begin
		next_state = state;
		next_remaining = remaining;
		next_inserted = inserted;
		next_address = address;
		next_from_dma = from_dma;
		next_fetch_n = fetch_n;
		next_refresh_grant = 1'b0;
		case (state)
			BWSG_ST_T1: begin
				if (i_cycle_valid) begin
					next_state = BWSG_ST_T2;
					next_address = i_cycle.address;
					next_from_dma = i_cycle.from_dma;
					next_fetch_n = ~fetch_low_for_request;
					next_remaining = decoded_waits;
					next_inserted = 3'h0;
				end else begin
					// Refresh is only granted between cycles, never in a wait.
					next_refresh_grant = i_refresh_request; // see R7
				end
			end
			BWSG_ST_T2: begin
				if (wait_needed) begin // see R3, R4
					next_state = BWSG_ST_TW;
					next_inserted = 3'(inserted + 3'h1);
					next_remaining = count_left ? 3'(remaining - 3'h1) : 3'h0; // see R20
				end else begin
					next_state = BWSG_ST_T3; // see R18
				end
			end
			BWSG_ST_TW: begin
				// Each wait state lasts one clock with address and flags held.
				if (wait_needed) begin // see R5, R19, R20
					next_state = BWSG_ST_TW;
					next_inserted = (inserted == 3'h7) ? inserted : 3'(inserted + 3'h1);
					next_remaining = count_left ? 3'(remaining - 3'h1) : 3'h0;
				end else begin
					next_state = BWSG_ST_T3; // see R3
				end
			end
			BWSG_ST_T3: begin
				next_state = BWSG_ST_T1;
				next_fetch_n = 1'b1;
			end
			default: next_state = BWSG_ST_T1;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			state <= BWSG_ST_T1;
			remaining <= 3'h0;
			inserted <= 3'h0;
			address <= 16'h0000;
			from_dma <= 1'b0;
			fetch_n <= 1'b1;
			refresh_grant <= 1'b0;
		end else if (i_enable) begin
			state <= next_state;
			remaining <= next_remaining;
			inserted <= next_inserted;
			address <= next_address;
			from_dma <= next_from_dma;
			fetch_n <= next_fetch_n;
			refresh_grant <= next_refresh_grant;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_cycle_ready = (state == BWSG_ST_T1) && i_enable;
	assign o_cycle_done = (state == BWSG_ST_T3) && i_enable;
	assign o_bus_active = (state != BWSG_ST_T1);
	assign o_address = address;
	assign o_from_dma = from_dma;
	assign o_last_instruction_fetch_n = fetch_n;
	assign o_in_wait = (state == BWSG_ST_TW);
	assign o_refresh_grant = refresh_grant;
	assign o_memory_wait_count = memory_wait_count_high_low;
	assign o_io_wait_count = io_wait_count_high_low;
	assign o_dma_and_wait_control = control;
	assign o_waits_inserted = inserted;

endmodule

// file: hw/bwsg_pkg.sv
// Purpose: Shared constants and types for the bus wait state generator.
// Assumes: One system clock at 25 MHz; synchronous active-high reset.
// Notes: Cycle kinds are one-hot so that decoding stays a single gate level.
package bwsg_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] BWSG_DMA_AND_WAIT_CONTROL_ADDR = 8'h32;
	localparam logic [7:0] BWSG_ONCHIP_IO_LAST = 8'h3f;
	localparam int BWSG_MEMORY_WAIT_POS = 6;
	localparam int BWSG_IO_WAIT_POS = 4;
	localparam logic [7:0] BWSG_CONTROL_RESET = 8'hf0;
	localparam logic [7:0] BWSG_WAIT_FIELD_MASK = 8'hf0;

	// ----------------------------------------
	// Wait counts
	// ----------------------------------------
	localparam logic [2:0] BWSG_INT_ACK_FIXED_WAITS = 3'h2;
	localparam logic [2:0] BWSG_NMI_ACK_WAITS = 3'h0;
	localparam logic [2:0] BWSG_ONCHIP_CTRL_WAITS = 3'h0;
	localparam logic [2:0] BWSG_ONCHIP_DATA_MAX_WAITS = 3'h4;

	// ----------------------------------------
	// Cycle kinds
	// ----------------------------------------
	typedef enum logic [6:0] {
		BWSG_KIND_MEMORY = 7'b000_0001,
		BWSG_KIND_EXT_IO = 7'b000_0010,
		BWSG_KIND_ONCHIP_IO = 7'b000_0100,
		BWSG_KIND_INT0_ACK = 7'b000_1000,
		BWSG_KIND_INT_OTHER_ACK = 7'b001_0000,
		BWSG_KIND_NMI_ACK = 7'b010_0000,
		BWSG_KIND_OPCODE = 7'b100_0000
	} bwsg_kind_e;

	typedef enum logic [3:0] {
		BWSG_ST_T1 = 4'b0001,
		BWSG_ST_T2 = 4'b0010,
		BWSG_ST_TW = 4'b0100,
		BWSG_ST_T3 = 4'b1000
	} bwsg_state_e;

	// One bus cycle request from the CPU or DMA sequencer.
	typedef struct packed {
		bwsg_kind_e kind;
		logic from_dma;
		logic [15:0] address;
		logic onchip_data_reg;
		logic [2:0] onchip_sync_waits;
	} bwsg_cycle_s;

	// Programmed register write from the on-chip I/O path.
	typedef struct packed {
		logic write;
		logic [7:0] address;
		logic [7:0] data;
	} bwsg_reg_write_s;

endpackage

// file: hw/bwsg_count_decode.sv
// Purpose: Turns a cycle request and the wait fields into a programmed wait count.
// Assumes: Request fields are stable while the decode is used.
// Notes: Pure combinational decode; registered by the caller.
module bwsg_count_decode
	import bwsg_pkg::*;
(
	input wire bwsg_cycle_s i_cycle,
	input wire logic [1:0] i_memory_wait,
	input wire logic [1:0] i_io_wait,
	input wire logic i_last_instruction_fetch_n,
	output logic [2:0] o_waits
);

	function automatic logic [2:0] int0_waits(input logic [1:0] code);
		case (code)
			2'h0: int0_waits = 3'h2;
			2'h1: int0_waits = 3'h4;
			2'h2: int0_waits = 3'h5;
			default: int0_waits = 3'h6;
		endcase
	endfunction

	always_comb begin
		o_waits = {1'b0, i_memory_wait};
		case (i_cycle.kind)
			BWSG_KIND_MEMORY, BWSG_KIND_OPCODE: o_waits = {1'b0, i_memory_wait}; // see R9
			BWSG_KIND_EXT_IO: o_waits = 3'({1'b0, i_io_wait} + 3'h1); // see R10
			BWSG_KIND_ONCHIP_IO: begin
				// The I/O wait field is ignored for on-chip registers.
				if (i_cycle.onchip_data_reg) begin // see R13
					o_waits = (i_cycle.onchip_sync_waits > BWSG_ONCHIP_DATA_MAX_WAITS) ?
						BWSG_ONCHIP_DATA_MAX_WAITS : i_cycle.onchip_sync_waits;
				end else begin
					o_waits = BWSG_ONCHIP_CTRL_WAITS; // see R14
				end
			end
			BWSG_KIND_INT0_ACK: begin
				// Vector reads run with the fetch output high and use memory timing.
				o_waits = i_last_instruction_fetch_n ? {1'b0, i_memory_wait} :
					int0_waits(i_io_wait); // see R11, R15
			end
			BWSG_KIND_INT_OTHER_ACK: begin
				// Fixed count; the vector reads that follow arrive as memory cycles.
				o_waits = BWSG_INT_ACK_FIXED_WAITS; // see R12
			end
			BWSG_KIND_NMI_ACK: begin
				o_waits = i_last_instruction_fetch_n ? {1'b0, i_memory_wait} :
					BWSG_NMI_ACK_WAITS; // see R12, R15
			end
			default: o_waits = {1'b0, i_memory_wait};
		endcase
	end

endmodule

// file: hw/bwsg_control_reg.sv
// Purpose: Holds the dma and wait control register with its wait fields.
// Assumes: Writes arrive on the on-chip I/O path, one per enabled cycle.
// Notes: The low four bits belong to the DMA and are kept but not used here.
module bwsg_control_reg
	import bwsg_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_enable,
	input wire bwsg_reg_write_s i_write,
	output logic [7:0] o_dma_and_wait_control
);

	logic [7:0] dma_and_wait_control;
	logic [7:0] next_dma_and_wait_control;

	always_comb begin
		next_dma_and_wait_control = dma_and_wait_control;
		if (i_write.write && i_write.address == BWSG_DMA_AND_WAIT_CONTROL_ADDR) begin
			next_dma_and_wait_control = i_write.data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			dma_and_wait_control <= BWSG_CONTROL_RESET; // see R16
		end else if (i_enable) begin
			dma_and_wait_control <= next_dma_and_wait_control;
		end
	end

	assign o_dma_and_wait_control = dma_and_wait_control;

endmodule

// file: sim/bwsg_wait_device.sv
// Purpose: Slow memory or I/O device that holds the wait pin low.
// Assumes: i_hold is the number of states it needs, 0 means fast.
// Notes: The pin idles high, driven high by the model after reset and when the hold count is done.
module bwsg_wait_device (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_start,
	input wire logic [2:0] i_hold,
	output logic o_wait_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] left;
	// The pin moves only on the rising edge so it is settled when sampled.
	always @(posedge i_clock) begin
		if (i_reset) begin
			o_wait_n <= 1'b1;
			left <= 3'h0;
		end else if (i_start && i_hold != 3'h0) begin
			o_wait_n <= 1'b0;
			left <= i_hold - 3'h1;
		end else if (left != 3'h0) begin
			left <= left - 3'h1;
		end else begin
			o_wait_n <= 1'b1;
		end
	end
endmodule

// file: sim/bwsg_top_checker.sv
// Purpose: Port level checks of the wait state sequencer.
// Assumes: One clock domain with a synchronous reset.
// Notes: Attached by bind below.
module bwsg_top_checker
	import bwsg_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_enable,
	input wire logic i_wait_n,
	input wire logic i_cycle_valid,
	input wire bwsg_cycle_s i_cycle,
	input wire bwsg_reg_write_s i_reg_write,
	input wire logic o_cycle_ready,
	input wire logic o_cycle_done,
	input wire logic o_bus_active,
	input wire logic [15:0] o_address,
	input wire logic o_from_dma,
	input wire logic o_in_wait,
	input wire logic o_refresh_grant,
	input wire logic [1:0] o_memory_wait_count,
	input wire logic [7:0] o_dma_and_wait_control
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_reset);
	sequence s_take;
		o_cycle_ready && i_cycle_valid && i_enable;
	endsequence
	sequence s_t2;
		o_bus_active && !o_in_wait && !o_cycle_done;
	endsequence
	property p_reset_value;
		$fell(i_reset) |-> o_dma_and_wait_control == BWSG_CONTROL_RESET;
	endproperty
	property p_write;
		i_enable && i_reg_write.write && i_reg_write.address == BWSG_DMA_AND_WAIT_CONTROL_ADDR
			|=> o_dma_and_wait_control == $past(i_reg_write.data);
	endproperty
	property p_wait_next;
		o_in_wait && i_enable |=> o_in_wait || o_cycle_done;
	endproperty
	property p_pin_extends;
		o_in_wait && !i_wait_n && i_enable |=> o_in_wait;
	endproperty
	property p_t2_pin;
		s_t2 ##0 (!i_wait_n && i_enable) |=> o_in_wait;
	endproperty
	property p_no_refresh;
		o_in_wait |-> !o_refresh_grant;
	endproperty
	property p_hold_addr;
		o_in_wait |-> $stable(o_address) && $stable(o_from_dma);
	endproperty
	property p_length;
		s_take |=> s_t2 ##[1:12] o_cycle_done;
	endproperty
	property p_mem0;
		s_take ##0 (i_cycle.kind == BWSG_KIND_MEMORY && o_memory_wait_count == 2'h0)
			##1 (s_t2 ##0 i_wait_n) |=> o_cycle_done;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("control not at reset value");
	a_write: assert property (p_write) else $error("control write lost");
	a_wait_next: assert property (p_wait_next) else $error("wait not followed by wait or T3");
	a_pin_extends: assert property (p_pin_extends) else $error("low pin did not extend");
	a_t2_pin: assert property (p_t2_pin) else $error("low pin in T2 gave no wait");
	a_no_refresh: assert property (p_no_refresh) else $error("refresh during wait");
	a_hold_addr: assert property (p_hold_addr) else $error("bus moved during wait");
	a_length: assert property (p_length) else $error("cycle shape wrong");
	a_mem0: assert property (p_mem0) else $error("memory code 0 cycle stretched");
endmodule
bind bwsg_top bwsg_top_checker u_chk (
	.i_clock(i_clock),
	.i_reset(i_reset),
	.i_enable(i_enable),
	.i_wait_n(i_wait_n),
	.i_cycle_valid(i_cycle_valid),
	.i_cycle(i_cycle),
	.i_reg_write(i_reg_write),
	.o_cycle_ready(o_cycle_ready),
	.o_cycle_done(o_cycle_done),
	.o_bus_active(o_bus_active),
	.o_address(o_address),
	.o_from_dma(o_from_dma),
	.o_in_wait(o_in_wait),
	.o_refresh_grant(o_refresh_grant),
	.o_memory_wait_count(o_memory_wait_count),
	.o_dma_and_wait_control(o_dma_and_wait_control)
);

// file: sim/bwsg_top_tb.sv
// Purpose: Self-checking bench of the wait state sequencer.
// Assumes: Enable is high except in one freeze test; a slow device drives the wait pin.
// Notes: Expected waits come from a small model of the wait fields.
module bwsg_top_tb
	import bwsg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic i_clock = 0, i_reset = 1, i_enable = 1, i_cycle_valid = 0;
	logic i_nmi_first_cycle = 0, i_refresh_request = 0, i_wait_n;
	bwsg_cycle_s i_cycle = '0;
	bwsg_reg_write_s i_reg_write = '0;
	logic o_cycle_ready, o_cycle_done, o_bus_active, o_from_dma, o_in_wait, o_refresh_grant;
	logic o_last_instruction_fetch_n;
	logic [15:0] o_address;
	logic [1:0] o_memory_wait_count, o_io_wait_count;
	logic [7:0] o_dma_and_wait_control;
	logic [2:0] o_waits_inserted, hold = 0;
	int n_mismatch = 0, n_checks = 0, m_code = 3, io_code = 3;
	bwsg_top dut (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_enable(i_enable),
		.i_wait_n(i_wait_n),
		.i_cycle_valid(i_cycle_valid),
		.i_cycle(i_cycle),
		.i_nmi_first_cycle(i_nmi_first_cycle),
		.i_reg_write(i_reg_write),
		.i_refresh_request(i_refresh_request),
		.o_cycle_ready(o_cycle_ready),
		.o_cycle_done(o_cycle_done),
		.o_bus_active(o_bus_active),
		.o_address(o_address),
		.o_from_dma(o_from_dma),
		.o_last_instruction_fetch_n(o_last_instruction_fetch_n),
		.o_in_wait(o_in_wait),
		.o_refresh_grant(o_refresh_grant),
		.o_memory_wait_count(o_memory_wait_count),
		.o_io_wait_count(o_io_wait_count),
		.o_dma_and_wait_control(o_dma_and_wait_control),
		.o_waits_inserted(o_waits_inserted)
	);
	bwsg_wait_device u_dev (.i_clock(i_clock), .i_reset(i_reset),
		.i_start(i_cycle_valid && o_cycle_ready), .i_hold(hold), .o_wait_n(i_wait_n));
	always #20 i_clock = ~i_clock;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function int exp_w(bwsg_cycle_s c, logic nf);
		case (c.kind)
			BWSG_KIND_EXT_IO: return io_code + 1;
			BWSG_KIND_ONCHIP_IO: return c.onchip_data_reg ? (c.onchip_sync_waits > 4 ? 4 :
				c.onchip_sync_waits) : 0;
			BWSG_KIND_INT0_ACK: return io_code == 0 ? 2 : io_code + 3;
			BWSG_KIND_INT_OTHER_ACK: return 2;
			BWSG_KIND_NMI_ACK: return nf ? 0 : m_code;
			default: return m_code;
		endcase
	endfunction
	task run(input bwsg_kind_e k, input logic [2:0] h);
		bwsg_cycle_s c;
		logic nf;
		int n, e;
		c = {k, 1'($urandom), 16'($urandom), 1'($urandom), 3'($urandom)};
		nf = 1'($urandom);
		e = exp_w(c, nf);
		e = e > h ? e : h;
		@(posedge i_clock);
		i_cycle <= c;
		hold <= h;
		i_nmi_first_cycle <= nf;
		i_refresh_request <= 1'($urandom);
		i_cycle_valid <= 1'b1;
		@(posedge i_clock);
		i_cycle_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge i_clock);
			n++;
			if (n == 1) begin
				chk(o_address, c.address);
				chk(16'(o_from_dma), 16'(c.from_dma));
				chk(o_last_instruction_fetch_n, !(k == BWSG_KIND_OPCODE ||
					k == BWSG_KIND_INT0_ACK || (k == BWSG_KIND_NMI_ACK && nf)));
			end
		end while (o_cycle_done !== 1'b1 && n < 16);
		chk(16'(n), 16'(2 + e));
		chk(o_waits_inserted, 16'(e));
		if (n == 16)
			end_sim();
	endtask
	task wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_write <= {1'b1, a, d};
		@(posedge i_clock);
		i_reg_write <= '0;
		if (a == 8'h32) begin
			m_code = d[7:6];
			io_code = d[5:4];
		end
		@(negedge i_clock);
		chk(o_memory_wait_count, 16'(m_code));
		chk(o_io_wait_count, 16'(io_code));
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h84c6_daae));
		repeat (3) @(posedge i_clock);
		i_reset <= 1'b0;
		@(negedge i_clock);
		chk(o_dma_and_wait_control, 8'hf0);
		run(BWSG_KIND_MEMORY, 3'h0);
		run(BWSG_KIND_EXT_IO, 3'h0);
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			for (int i = 0; i < 4; i++) begin
				wreg(8'h32, {m[1:0], i[1:0], 4'($urandom)});
				for (int k = 0; k < 7; k++)
					run(bwsg_kind_e'(7'(1 << k)), k % 2 ? 3'($urandom_range(5)) : 3'h0);
			end
		end
		$display("test wait codes done");
		wreg(8'h33, 8'h00);
		@(posedge i_clock);
		i_refresh_request <= 1'b1;
		@(posedge i_clock);
		i_refresh_request <= 1'b0;
		@(negedge i_clock);
		chk(o_refresh_grant, 1'b1);
		$display("test register and refresh done");
		@(posedge i_clock);
		i_enable <= 1'b0;
		i_reg_write <= {1'b1, BWSG_DMA_AND_WAIT_CONTROL_ADDR, 8'h00};
		repeat (2) @(negedge i_clock);
		chk(16'(o_cycle_ready), 16'h0000);
		@(posedge i_clock);
		i_enable <= 1'b1;
		i_reg_write <= '0;
		@(negedge i_clock);
		chk(o_memory_wait_count, 16'(m_code));
		chk(o_io_wait_count, 16'(io_code));
		$display("test clock enable done");
		end_sim();
	end
endmodule
